// ### logic/ierr_pkg.sv
// constants shared by the interrupt enable and request register block
// assumes a 16-bit byte-addressed special function register space
//
// Overview of operation
// - absent peripheral bits ignore writes, read zero
// - acceptance clears master enable, keeps enable bits
// - 16-bit registers, reset zero, byte or word access
// - enable bit 0 masks, 1 enables
// - upper enable layout, bits 15 and 11 reserved
// - watchdog request bypasses the master enable
// - hardware sets request flag regardless of enables
// - request forwarded only when its enable is one; watchdog is forwarded whatever ieLow bit 0 holds
// - maskable interrupt accepted only with master enable
// - software write of one raises the interrupt
// - software request waits exactly one further instruction
// - accepted request flag clears automatically
// - request bit 0 none, 1 requested; resets zero
// - low request layout, pins, low voltage, watchdog
// - middle request layout, reserved bits 9 7 5
// - low enable bits match low request positions
// - middle enable bits match middle request positions
package ierr_pkg;
   // =========================================================
   // register addresses, low byte at even, high byte at odd
   // =========================================================
   localparam logic [15:0] ADDR_IE_LOW = 16'hf020;
   localparam logic [15:0] ADDR_IE_MID = 16'hf022;
   localparam logic [15:0] ADDR_IE_UPPER = 16'hf026;
   localparam logic [15:0] ADDR_RQ_LOW = 16'hf028;
   localparam logic [15:0] ADDR_RQ_MID = 16'hf02a;

   // =========================================================
   // implemented bits, reserved ones stay zero
   // =========================================================
   localparam logic [15:0] BITS_LOW = 16'hff41;
   localparam logic [15:0] BITS_MID = 16'hfd5f;
   localparam logic [15:0] BITS_UPPER = 16'h77ff;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // =========================================================
   // field positions
   // =========================================================
   localparam int WATCHDOG_BIT = 0;
   localparam int VEC_W = 5;
   localparam int SRC_COUNT = 32;

   // kind of register access carried on the sfr port
   typedef enum logic [1:0]
   {
      ACC_NONE = 2'b00,
      ACC_BYTE = 2'b01,
      ACC_WORD = 2'b10,
      ACC_BIT = 2'b11
   } ierr_access_e;
endpackage : ierr_pkg

// ### logic/ierr_prio_enc.sv
// fixed priority encoder, lowest index wins
// assumes a combinational request vector from the same clock domain
`timescale 1ns/1ns
module ierr_prio_enc
   import ierr_pkg::*;
#(
   parameter int WIDTH = SRC_COUNT
)
(
   input wire logic [WIDTH-1:0] reqVec,
   output logic anyReq,
   output logic [VEC_W-1:0] reqIndex
);
   // =========================================================
   // scan from the top so the lowest index is kept last
   // =========================================================
   always_comb
   begin
      anyReq = 1'b0;
      reqIndex = '0;
      for (int i = WIDTH - 1; i >= 0; i--)
      begin
         if (reqVec[i])
         begin
            anyReq = 1'b1;
            reqIndex = VEC_W'(i);
         end
      end
   end
endmodule : ierr_prio_enc

// ### logic/ierr_irq_regs.sv
// interrupt enable and request registers with request arbitration
// assumes sfr accesses, sources and cpu handshake share core_clk
`timescale 1ns/1ns
module ierr_irq_regs
   import ierr_pkg::*;
#(
   // bits of peripherals present in this product
   parameter logic [15:0] PRESENT_LOW = BITS_LOW,
   parameter logic [15:0] PRESENT_MID = BITS_MID,
   parameter logic [15:0] PRESENT_UPPER = BITS_UPPER
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   // special function register port
   input wire logic [15:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [1:0] sfrSize,
   input wire logic [2:0] sfrBitSel,
   input wire logic [15:0] sfrWrData,
   output logic [15:0] sfrRdData,
   output logic sfrRdValid,
   // peripheral request pulses
   input wire logic [15:0] srcReqLow,
   input wire logic [15:0] srcReqMid,
   input wire logic watchdogInterrupt,
   // cpu side
   input wire logic mieSet,
   input wire logic mieClear,
   input wire logic instrDone,
   input wire logic cpuAccept,
   output logic masterIrqEnable,
   output logic irqPending,
   output logic [VEC_W-1:0] irqIndex,
   output logic irqNmi,
   output logic [15:0] irqEnableUpperGroup
);
   // =========================================================
   // state of the block
   // =========================================================
   typedef struct packed
   {
      logic [15:0] ieLow;
      logic [15:0] ieMid;
      logic [15:0] ieUpper;
      logic [15:0] rqLow;
      logic [15:0] rqMid;
      logic [SRC_COUNT-1:0] swHold;
      logic master_irq_enable;
      logic pend;
      logic [VEC_W-1:0] index;
      logic nmi;
      logic [15:0] rdData;
      logic rdValid;
   } ierr_state_s;

   localparam ierr_state_s STATE_RESET = '{
      ieLow: REG_RESET,
      ieMid: REG_RESET,
      ieUpper: REG_RESET,
      rqLow: REG_RESET,
      rqMid: REG_RESET,
      swHold: '0,
      master_irq_enable: 1'b0,
      pend: 1'b0,
      index: '0,
      nmi: 1'b0,
      rdData: REG_RESET,
      rdValid: 1'b0
   };

   localparam logic [15:0] MASK_LOW = PRESENT_LOW & BITS_LOW;
   localparam logic [15:0] MASK_MID = PRESENT_MID & BITS_MID;
   localparam logic [15:0] MASK_UPPER = PRESENT_UPPER & BITS_UPPER;

   ierr_state_s st;
   ierr_state_s next_st;
   logic [SRC_COUNT-1:0] eligible;
   logic encAny;
   logic [VEC_W-1:0] encIndex;

   // =========================================================
   // helpers for byte, word and bit writes and for reads
   // =========================================================
   // lanes touched by one access; odd address selects the high byte
   function automatic logic [15:0] writeMask(input ierr_access_e kind,
                                             input logic odd,
                                             input logic [2:0] bitSel);
      logic [15:0] m;
      m = 16'h0000;
      case (kind)
         ACC_WORD: m = 16'hffff;
         ACC_BYTE: m = odd ? 16'hff00 : 16'h00ff;
         ACC_BIT: m = 16'h0001 << {odd, bitSel};
         default: m = 16'h0000;
      endcase
      return m;
   endfunction : writeMask

   // data replicated so every lane kind lines up with the mask
   function automatic logic [15:0] writeData(input ierr_access_e kind,
                                             input logic [15:0] wd);
      logic [15:0] d;
      d = 16'h0000;
      case (kind)
         ACC_WORD: d = wd;
         ACC_BYTE: d = {wd[7:0], wd[7:0]};
         ACC_BIT: d = {16{wd[0]}};
         default: d = 16'h0000;
      endcase
      return d;
   endfunction : writeData

   // merged value, limited to implemented bits
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] m,
                                         input logic [15:0] d,
                                         input logic [15:0] impl);
      return ((old & ~m) | (d & m)) & impl;
   endfunction : merge

   // byte or word view of a register for the read port
   function automatic logic [15:0] readView(input ierr_access_e kind,
                                            input logic odd,
                                            input logic [15:0] r);
      logic [15:0] v;
      v = 16'h0000;
      case (kind)
         ACC_WORD: v = r;
         ACC_BYTE, ACC_BIT: v = odd ? {8'h00, r[15:8]} : {8'h00, r[7:0]};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : readView

   // =========================================================
   // arbitration over the settled next values
   // =========================================================
   ierr_prio_enc #(
      .WIDTH(SRC_COUNT)
   ) u_prio (
      .reqVec(eligible),
      .anyReq(encAny),
      .reqIndex(encIndex)
   );

   // =========================================================
   // next state
   // =========================================================
   always_comb
   begin
      ierr_access_e kind;
      logic odd;
      logic [15:0] wm;
      logic [15:0] wd;
      logic [15:0] regSel;
      logic [15:0] oldLow;
      logic [15:0] oldMid;
      logic [SRC_COUNT-1:0] ackClr;
      logic [SRC_COUNT-1:0] swSet;
      logic [SRC_COUNT-1:0] pendVec;
      logic [SRC_COUNT-1:0] allow;
      logic [15:0] hwLow;
      kind = ierr_access_e'(sfrSize);
      odd = sfrAddr[0];
      wm = writeMask(kind, odd, sfrBitSel);
      wd = writeData(kind, sfrWrData);
      regSel = {sfrAddr[15:1], 1'b0};
      oldLow = st.rqLow;
      oldMid = st.rqMid;
      ackClr = '0;
      swSet = '0;
      pendVec = '0;
      allow = '0;
      hwLow = 16'h0000;
      next_st = st;

      // register writes; absent and reserved bits never take a value
      if (sfrWrite)
      begin
         case (regSel)
            ADDR_IE_LOW: next_st.ieLow = merge(st.ieLow, wm, wd, MASK_LOW);
            ADDR_IE_MID: next_st.ieMid = merge(st.ieMid, wm, wd, MASK_MID);
            ADDR_IE_UPPER:
               next_st.ieUpper = merge(st.ieUpper, wm, wd, MASK_UPPER);
            ADDR_RQ_LOW: next_st.rqLow = merge(st.rqLow, wm, wd, MASK_LOW);
            ADDR_RQ_MID: next_st.rqMid = merge(st.rqMid, wm, wd, MASK_MID);
            default: next_st = st; // unmapped writes are dropped
         endcase
      end

      // a flag turned on by software waits for one instruction
      swSet = {next_st.rqMid & ~oldMid, next_st.rqLow & ~oldLow};

      // the accepted flag clears itself
      if (cpuAccept && st.pend)
      begin
         ackClr[st.index] = 1'b1;
         next_st.master_irq_enable = 1'b0;
      end
      next_st.rqLow = next_st.rqLow & ~ackClr[15:0];
      next_st.rqMid = next_st.rqMid & ~ackClr[31:16];

      // hardware sets win over software or acceptance clears
      hwLow = srcReqLow & ~16'h0001;
      hwLow[WATCHDOG_BIT] = watchdogInterrupt;
      next_st.rqLow = next_st.rqLow | (hwLow & MASK_LOW);
      next_st.rqMid = next_st.rqMid | (srcReqMid & MASK_MID);

      // master enable; acceptance clears it in preference to a set
      if (!(cpuAccept && st.pend))
      begin
         if (mieClear)
         begin
            next_st.master_irq_enable = 1'b0;
         end
         else if (mieSet)
         begin
            next_st.master_irq_enable = 1'b1;
         end
      end

      // hold ends at the next completed instruction, or with the flag
      if (instrDone)
      begin
         next_st.swHold = '0;
      end
      next_st.swHold = (next_st.swHold | swSet)
                       & {next_st.rqMid, next_st.rqLow};

      // forward only enabled flags; watchdog ignores its enable bit, ieLow bit 0
      pendVec = {next_st.rqMid & next_st.ieMid, next_st.rqLow & next_st.ieLow};
      pendVec[WATCHDOG_BIT] = next_st.rqLow[WATCHDOG_BIT];
      allow = next_st.master_irq_enable ? '1 : SRC_COUNT'(1) << WATCHDOG_BIT;
      eligible = pendVec & allow & ~next_st.swHold;

      // one presented source at a time
      next_st.pend = encAny;
      next_st.index = encIndex;
      next_st.nmi = encAny && (encIndex == VEC_W'(WATCHDOG_BIT));

      // registered read answer; reserved bits read zero
      next_st.rdValid = sfrRead;
      next_st.rdData = 16'h0000;
      if (sfrRead)
      begin
         case (regSel)
            ADDR_IE_LOW: next_st.rdData = readView(kind, odd, st.ieLow);
            ADDR_IE_MID: next_st.rdData = readView(kind, odd, st.ieMid);
            ADDR_IE_UPPER: next_st.rdData = readView(kind, odd, st.ieUpper);
            ADDR_RQ_LOW: next_st.rdData = readView(kind, odd, st.rqLow);
            ADDR_RQ_MID: next_st.rdData = readView(kind, odd, st.rqMid);
            default: next_st.rdData = 16'h0000;
         endcase
      end
   end

   // =========================================================
   // state register, synchronous reset to all zeros
   // =========================================================
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         st <= STATE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // =========================================================
   // outputs straight from the state register
   // =========================================================
   // the enable bits of the upper group are left untouched on acceptance
   assign irqEnableUpperGroup = st.ieUpper;
   assign masterIrqEnable = st.master_irq_enable;
   assign irqPending = st.pend;
   assign irqIndex = st.index;
   assign irqNmi = st.nmi;
   assign sfrRdData = st.rdData;
   assign sfrRdValid = st.rdValid;
endmodule : ierr_irq_regs

// ### test/ierr_irq_asserts.sv
// checker for the interrupt enable and request register block
// assumes binding to ierr_irq_regs, one clock, synchronous reset
`timescale 1ns/1ns
module ierr_irq_asserts
   import ierr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [1:0] sfrSize,
   input wire logic [15:0] srcReqLow,
   input wire logic [15:0] srcReqMid,
   input wire logic watchdogInterrupt,
   input wire logic mieSet,
   input wire logic cpuAccept,
   input wire logic [15:0] sfrRdData,
   input wire logic sfrRdValid,
   input wire logic masterIrqEnable,
   input wire logic irqPending,
   input wire logic [VEC_W-1:0] irqIndex,
   input wire logic irqNmi,
   input wire logic [15:0] irqEnableUpperGroup
);
   // ===========================================
   // sequences of the accept handshake and reads
   // ===========================================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence takeIrq;
      cpuAccept && irqPending;
   endsequence
   sequence quietSrc;
      srcReqLow == 16'h0000 && srcReqMid == 16'h0000 && !watchdogInterrupt;
   endsequence
   sequence byteRd;
      sfrRead && sfrSize == ACC_BYTE;
   endsequence
   // one-cycle read answer, high byte empty on byte reads
   read_valid_a: assert property (sfrRdValid == $past(sfrRead))
      else $error("read valid not one cycle after read");
   byte_high_a: assert property (byteRd |=> sfrRdData[15:8] == 8'h00)
      else $error("byte read high byte not zero");
   // acceptance clears master enable and the flag, keeps the upper group enables
   mie_clear_a: assert property (takeIrq ##0 !mieSet |=> !masterIrqEnable)
      else $error("master enable kept after accept");
   enable_kept_a: assert property (takeIrq ##0 !sfrWrite |=> $stable(irqEnableUpperGroup))
      else $error("enable register changed on accept");
   flag_cleared_a: assert property (takeIrq and quietSrc |=>
      !(irqPending && irqIndex == $past(irqIndex)))
      else $error("accepted request still presented");
   upper_resv_a: assert property (irqEnableUpperGroup[15] == 1'b0 &&
      irqEnableUpperGroup[11] == 1'b0)
      else $error("reserved enable bit set");
   // maskable only with master enable; watchdog bypasses it
   mask_mie_a: assert property (irqPending && !irqNmi |->
      masterIrqEnable || $fell(masterIrqEnable))
      else $error("maskable request shown with master enable off");
   wdt_pend_a: assert property (watchdogInterrupt |=> irqPending && irqNmi)
      else $error("watchdog request not presented");
   nmi_index_a: assert property (irqNmi |-> irqPending && irqIndex == 5'h00)
      else $error("watchdog not at top priority index");
endmodule : ierr_irq_asserts

bind ierr_irq_regs ierr_irq_asserts chk_i (.core_clk, .rst_n, .sfrWrite, .sfrRead,
   .sfrSize, .srcReqLow, .srcReqMid, .watchdogInterrupt, .mieSet, .cpuAccept, .sfrRdData,
   .sfrRdValid, .masterIrqEnable, .irqPending, .irqIndex, .irqNmi, .irqEnableUpperGroup);

// ### test/ierr_cpu_model.sv
// cpu core model: accepts presented interrupts, retires instructions
// assumes bench commands change by non-blocking assignment
`timescale 1ns/1ns
module ierr_cpu_model
(
   input wire logic core_clk,
   input wire logic takeOn,
   input wire logic stepOn,
   input wire logic irqPending,
   output logic cpuAccept,
   output logic instrDone
);
   // ===========================================
   // falling-edge drive keeps clear of the sampling edge
   // ===========================================
   initial
   begin
      cpuAccept = 1'b0;
      instrDone = 1'b0;
   end
   // a gap after each pulse lets the next presentation settle
   always @(negedge core_clk)
   begin
      cpuAccept <= takeOn && irqPending && !cpuAccept;
      instrDone <= stepOn && !instrDone;
   end
endmodule : ierr_cpu_model

// ### test/ierr_irq_regs_tb.sv
// self-checking bench for the enable and request register block
// assumes the cpu model in ierr_cpu_model and the bound checker
`timescale 1ns/1ns
module ierr_irq_regs_tb
   import ierr_pkg::*;
;
   logic core_clk = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
   logic [15:0] sfrAddr = 16'h0000, sfrWrData = 16'h0000, sfrRdData;
   logic [1:0] sfrSize = ACC_NONE;
   logic [2:0] sfrBitSel = 3'h0;
   logic [15:0] srcReqLow = 16'h0000, srcReqMid = 16'h0000, irqEnableUpperGroup;
   logic watchdogInterrupt = 1'b0, mieSet = 1'b0, takeOn = 1'b0, stepOn = 1'b0;
   logic mieClear = 1'b0;
   logic sfrRdValid, masterIrqEnable, irqPending, irqNmi, cpuAccept, instrDone;
   logic [VEC_W-1:0] irqIndex;
   int mismatches = 0, check_count = 0;
   ierr_irq_regs dut (.core_clk, .rst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrSize,
      .sfrBitSel, .sfrWrData, .sfrRdData, .sfrRdValid, .srcReqLow, .srcReqMid,
      .watchdogInterrupt, .mieSet, .mieClear, .instrDone, .cpuAccept,
      .masterIrqEnable, .irqPending, .irqIndex, .irqNmi, .irqEnableUpperGroup);
   ierr_cpu_model cpu (.core_clk, .takeOn, .stepOn, .irqPending, .cpuAccept, .instrDone);
   // ===========================================
   // shared bus, source and compare tasks
   // ===========================================
   task automatic give_verdict;
      if (mismatches == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [1:0] sz, input logic [2:0] b,
      input logic [15:0] d);
      @(negedge core_clk);
      {sfrAddr, sfrSize, sfrBitSel, sfrWrData, sfrWrite} = {a, sz, b, d, 1'b1};
      @(negedge core_clk);
      sfrWrite = 1'b0;
   endtask : wr
   // read answer stands for one cycle, so it is taken at the next fall
   task automatic rd(input logic [15:0] a, input logic [1:0] sz, input logic [15:0] exp);
      @(negedge core_clk);
      {sfrAddr, sfrSize, sfrRead} = {a, sz, 1'b1};
      @(negedge core_clk);
      sfrRead = 1'b0;
      chk("read valid", 16'h0001, 16'(sfrRdValid));
      chk("read data", exp, sfrRdData);
   endtask : rd
   task automatic src(input logic [15:0] lo, input logic [15:0] mi, input logic wd,
      input logic ms);
      @(negedge core_clk);
      {srcReqLow, srcReqMid, watchdogInterrupt, mieSet} = {lo, mi, wd, ms};
      @(negedge core_clk);
      {srcReqLow, srcReqMid, watchdogInterrupt, mieSet} = '0;
   endtask : src
   // bounded waits: a hang counts as a mismatch and ends the run
   task automatic expPend(input logic [VEC_W-1:0] idx);
      int n;
      for (n = 0; n < 20 && irqPending !== 1'b1; n++)
         @(negedge core_clk);
      if (n == 20)
         mismatches++;
      if (n == 20)
         give_verdict();
      chk("irq index", 16'(idx), 16'(irqIndex));
   endtask : expPend
   task automatic take;
      int n;
      takeOn <= 1'b1;
      for (n = 0; n < 20 && cpuAccept !== 1'b1; n++)
         @(negedge core_clk);
      takeOn <= 1'b0;
      if (n == 20)
         mismatches++;
      if (n == 20)
         give_verdict();
      chk("master enable", 16'h0000, 16'(masterIrqEnable));
   endtask : take
   // ===========================================
   // scenarios
   // ===========================================
   task automatic t_reset;
      logic [15:0] regs [5] = '{ADDR_IE_LOW, ADDR_IE_MID, ADDR_IE_UPPER, ADDR_RQ_LOW, ADDR_RQ_MID};
      foreach (regs[i])
         rd(regs[i], ACC_WORD, 16'h0000);
   endtask : t_reset
   task automatic t_layout;
      wr(ADDR_IE_UPPER, ACC_WORD, 3'h0, 16'hffff);
      rd(ADDR_IE_UPPER, ACC_WORD, 16'h77ff);
      wr(ADDR_IE_UPPER + 16'h1, ACC_BYTE, 3'h0, 16'h0000);
      rd(ADDR_IE_UPPER, ACC_WORD, 16'h00ff);
      chk("upper enable", 16'h00ff, irqEnableUpperGroup);
      wr(ADDR_RQ_MID, ACC_WORD, 3'h0, 16'hffff);
      rd(ADDR_RQ_MID, ACC_WORD, 16'hfd5f);
      wr(ADDR_RQ_LOW, ACC_WORD, 3'h0, 16'hfffe);
      rd(ADDR_RQ_LOW + 16'h1, ACC_BYTE, 16'h00ff);
      rd(ADDR_RQ_LOW, ACC_WORD, 16'hff40);
      chk("pending masked", 16'h0000, 16'(irqPending));
      wr(16'hf030, ACC_WORD, 3'h0, 16'hffff);
      rd(16'hf030, ACC_WORD, 16'h0000);
      wr(ADDR_RQ_LOW, ACC_WORD, 3'h0, 16'h0000);
      wr(ADDR_RQ_MID, ACC_WORD, 3'h0, 16'h0000);
      wr(ADDR_IE_UPPER, ACC_WORD, 3'h0, 16'h0000);
   endtask : t_layout
   task automatic t_hw;
      src(16'h0000, 16'h0002, 1'b0, 1'b0);
      rd(ADDR_RQ_MID, ACC_WORD, 16'h0002);
      chk("pending masked", 16'h0000, 16'(irqPending));
      wr(ADDR_IE_MID, ACC_WORD, 3'h0, 16'h0002);
      src(16'h0000, 16'h0000, 1'b0, 1'b1);
      expPend(5'h11);
      take();
      rd(ADDR_RQ_MID, ACC_WORD, 16'h0000);
      rd(ADDR_IE_MID, ACC_WORD, 16'h0002);
   endtask : t_hw
   task automatic t_wdt;
      src(16'h0000, 16'h0000, 1'b1, 1'b0);
      expPend(5'h00);
      chk("nmi flag", 16'h0001, 16'(irqNmi));
      rd(ADDR_RQ_LOW, ACC_WORD, 16'h0001);
      take();
      rd(ADDR_RQ_LOW, ACC_WORD, 16'h0000);
   endtask : t_wdt
   task automatic t_sw;
      wr(ADDR_IE_LOW, ACC_WORD, 3'h0, 16'h0140);
      src(16'h0000, 16'h0000, 1'b0, 1'b1);
      wr(ADDR_RQ_LOW, ACC_BIT, 3'h6, 16'h0001);
      repeat (3) @(negedge core_clk);
      chk("held request", 16'h0000, 16'(irqPending));
      stepOn <= 1'b1;
      @(negedge core_clk);
      stepOn <= 1'b0;
      expPend(5'h06);
      take();
   endtask : t_sw
   task automatic t_prio;
      src(16'h0100, 16'h0002, 1'b0, 1'b1);
      @(negedge core_clk);
      mieClear = 1'b1;
      @(negedge core_clk);
      mieClear = 1'b0;
      chk("master enable", 16'h0000, 16'(masterIrqEnable));
      chk("pending no mie", 16'h0000, 16'(irqPending));
      src(16'h0000, 16'h0000, 1'b0, 1'b1);
      expPend(5'h08);
      take();
      src(16'h0000, 16'h0000, 1'b0, 1'b1);
      expPend(5'h11);
      take();
   endtask : t_prio
   // ===========================================
   // clock, reset and main sequence
   // ===========================================
   initial
   begin
      forever #25 core_clk = ~core_clk;
   end
   initial
   begin
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_layout();
      t_hw();
      t_wdt();
      t_sw();
      t_prio();
      give_verdict();
   end
endmodule : ierr_irq_regs_tb
